// ===== rtl/pias_pkg.sv
package pias_pkg;

  // ****************************************************************
  // sizes and priority range
  // ****************************************************************
  localparam int unsigned NUM_IN       = 5;
  localparam int unsigned NUM_OUT      = 2;
  localparam int unsigned IN_W         = 3;
  localparam int unsigned PRIO_W       = 7;
  localparam logic [6:0]  PRIO_HIGHEST = 7'h01;
  localparam logic [6:0]  PRIO_LOWEST  = 7'h64;
  localparam logic [6:0]  PRIO_OFF     = 7'h00;
  localparam logic [6:0]  PRIO_RST     = 7'h32;
  localparam logic [6:0]  PRIO_WS_RST  = 7'h64;
  localparam logic [2:0]  USB_C_IDX    = 3'h0;
  localparam logic [2:0]  WS_IDX       = 3'h4;
  localparam logic [2:0]  NO_INPUT     = 3'h7;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] MANUAL_OFS   = 12'h004;
  localparam logic [11:0] STATUS_OFS   = 12'h008;
  localparam logic [11:0] PRIO_BASE    = 12'h040;
  localparam logic [11:0] PRIO_STRIDE  = 12'h020;
  localparam logic [11:0] ROUTE_BASE   = 12'h100;

  // ctrl word: per output, 2-bit video policy then 2-bit follow policy
  localparam int unsigned CTRL_FLD_W   = 4;
  // manual word: [2:0] input, [10:8] output, [16] layer (0 video, 1 follow)
  localparam int unsigned MAN_OUT_LSB  = 8;
  localparam int unsigned MAN_LAYER    = 16;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  // ****************************************************************
  // selection policies
  // ****************************************************************
  typedef enum logic [1:0] {
    PIAS_DISABLED = 2'b00,
    PIAS_FIRST    = 2'b01,
    PIAS_LAST     = 2'b11,
    PIAS_FOLLOW   = 2'b10
  } pias_policy_t;

endpackage : pias_pkg

// ===== rtl/pias_pick.sv
`timescale 1ns/10ps
// one output's choice among the inputs, recomputed every cycle
module pias_pick #(
  parameter int unsigned NI = pias_pkg::NUM_IN
) (
  input  wire logic [NI-1:0]                    active,
  input  wire logic [NI-1:0]                    new_act,
  input  wire logic [NI*pias_pkg::PRIO_W-1:0]   prio,
  input  wire logic [2:0]                       cur,
  input  wire logic                             last_mode,
  output logic                                  change,
  output logic      [2:0]                       pick
);

  logic [pias_pkg::PRIO_W-1:0] best_p;
  logic [pias_pkg::PRIO_W-1:0] cur_p;
  logic [pias_pkg::PRIO_W-1:0] p;
  logic                        cur_ok;
  logic                        chall;

  always_comb
  begin
    best_p = pias_pkg::PRIO_LOWEST + 7'h01;
    pick   = pias_pkg::NO_INPUT;
    cur_p  = pias_pkg::PRIO_LOWEST + 7'h01;
    cur_ok = 1'b0;
    chall  = 1'b0;
    for (int i = 0; i < NI; i++)
    begin
      p = prio[i*pias_pkg::PRIO_W +: pias_pkg::PRIO_W];
      // a disabled entry never takes part
      if (active[i] && p != pias_pkg::PRIO_OFF)
      begin
        // strict less keeps the lowest index on a tie
        if (p < best_p)
        begin
          best_p = p;
          pick   = 3'(i);
        end
        if (3'(i) == cur)
        begin
          cur_ok = 1'b1;
          cur_p  = p;
        end
      end
    end
    // a lost current is judged by the best survivor, so a newcomer never beats a better input
    if (!cur_ok)
    begin
      cur_p = best_p;
    end
    for (int i = 0; i < NI; i++)
    begin
      p = prio[i*pias_pkg::PRIO_W +: pias_pkg::PRIO_W];
      if (new_act[i] && p != pias_pkg::PRIO_OFF && 3'(i) != cur)
      begin
        if (last_mode ? (p <= cur_p) : (p < cur_p))
        begin
          chall = 1'b1;
          if (last_mode)
          begin
            pick = 3'(i);
          end
        end
      end
    end
    // priority, not arrival, decides unless a newcomer ties in last mode
    if (chall && !last_mode)
    begin
      change = 1'b1;
    end
    else
    begin
      change = !cur_ok || chall;
    end
  end

endmodule : pias_pick

// ===== rtl/pias_top.sv
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
// How it works
// - each output runs disabled, first detect or last detect on video, and the follow layer may also track video.
// - every input holds a priority where 1 is highest and 100 lowest.
// - when selecting automatically the active input of highest priority is routed.
// - priority beats the order in which signals arrived in both detect modes.
// - with selection disabled the route moves only on a manual request or when usb-c displaces the welcome screen.
// - in first detect the chosen input stays while it is active and no strictly higher priority input appears.
// - first detect reselects when the chosen input drops or a strictly higher priority input appears.
// - last detect takes the newest active input and reselects on a drop or an equal or higher newcomer.
// - a manual change leaves the policy running, which may later override it.
// - while the welcome screen is routed the usb-c activity indication is not sensed.
// - attaching a host to usb-c drops the welcome screen and routes usb-c, picture or not.
// - usb-c and the welcome screen are never routed to video at the same time.
// - while the welcome screen is in use usb-c audio is not de-embedded and embedded audio reads absent.
module pias_top #(
  parameter int unsigned NI = pias_pkg::NUM_IN,
  parameter int unsigned NO = pias_pkg::NUM_OUT
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [NI-1:0]        active_signal_flag,
  input  wire logic                 usb_c_host_attached,
  input  wire logic                 usb_c_audio_present,
  input  wire logic [2:0]           audio_src_sel,
  output logic      [NO*3-1:0]      video_route,
  output logic      [NO*3-1:0]      follow_route,
  output logic                      usb_c_audio_to_analog,
  output logic                      embedded_audio_present
);

  localparam int unsigned PW = pias_pkg::PRIO_W;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [NI+1:0] sync1_r;
  logic [NI+1:0] sync2_r;
  logic [NI+1:0] sync_nxt;
  logic [NI-1:0] act_prev_r;
  logic          host_att;
  logic          aud_pres;
  logic          ws_routed;
  logic [NI-1:0] act_seen;
  logic [NI-1:0] rise;

  always_comb
  begin
    sync_nxt = {usb_c_audio_present, usb_c_host_attached, active_signal_flag};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      act_prev_r <= '0;
    end
    else
    begin
      sync1_r    <= sync_nxt;
      sync2_r    <= sync1_r;
      // edges follow the sensed view, so a forced or blinded input rises once, not every cycle
      act_prev_r <= act_seen;
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic                    wr_pend_r;
  logic [11:0]             wr_addr_r;
  logic [31:0]             ctrl_r;
  logic [31:0]             ctrl_nxt;
  logic [NO*NI*PW-1:0]     prio_r;
  logic [NO*NI*PW-1:0]     prio_nxt;
  logic                    man_vld;
  logic                    man_layer;
  logic [2:0]              man_in;
  logic [2:0]              man_out;
  logic [31:0]             rdata_nxt;
  logic                    acc;

  function automatic logic [31:0] prio_word(input logic [NO*NI*PW-1:0] tab, input int unsigned o,
                                            input int unsigned i);
    prio_word = {25'h000_0000, tab[(o*NI+i)*PW +: PW]};
  endfunction : prio_word

  assign acc = hsel && hready && htrans[1];

  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    prio_nxt  = prio_r;
    man_vld   = 1'b0;
    man_layer = hwdata[pias_pkg::MAN_LAYER];
    man_in    = hwdata[2:0];
    man_out   = hwdata[pias_pkg::MAN_OUT_LSB +: 3];
    if (wr_pend_r)
    begin
      if (wr_addr_r == pias_pkg::CTRL_OFS)
      begin
        ctrl_nxt = hwdata;
      end
      if (wr_addr_r == pias_pkg::MANUAL_OFS)
      begin
        man_vld = 32'(man_out) < NO && 32'(man_in) < NI;
      end
      for (int o = 0; o < NO; o++)
      begin
        for (int i = 0; i < NI; i++)
        begin
          // values above the lowest priority are clamped to it
          if (wr_addr_r == pias_pkg::PRIO_BASE + 12'(o) * pias_pkg::PRIO_STRIDE + 12'(i * 4))
          begin
            prio_nxt[(o*NI+i)*PW +: PW] = (hwdata[PW-1:0] > pias_pkg::PRIO_LOWEST) ?
                                          pias_pkg::PRIO_LOWEST : hwdata[PW-1:0];
          end
        end
      end
    end
    rdata_nxt = 32'h0000_0000;
    if (haddr[11:0] == pias_pkg::CTRL_OFS)
    begin
      rdata_nxt = ctrl_r;
    end
    if (haddr[11:0] == pias_pkg::STATUS_OFS)
    begin
      rdata_nxt = {21'h00_0000, embedded_audio_present, usb_c_audio_to_analog, ws_routed, host_att,
                   2'(0), act_seen};
    end
    if (haddr[11:0] == pias_pkg::ROUTE_BASE)
    begin
      // follow layer sits in the upper half word
      rdata_nxt = {16'(follow_route), 16'(video_route)};
    end
    for (int o = 0; o < NO; o++)
    begin
      for (int i = 0; i < NI; i++)
      begin
        if (haddr[11:0] == pias_pkg::PRIO_BASE + 12'(o) * pias_pkg::PRIO_STRIDE + 12'(i * 4))
        begin
          rdata_nxt = prio_word(prio_r, o, i);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      ctrl_r    <= pias_pkg::CTRL_RST;
      prio_r    <= {NO{pias_pkg::PRIO_WS_RST, {(NI-1){pias_pkg::PRIO_RST}}}};
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_r <= acc && hwrite;
      wr_addr_r <= haddr[11:0];
      ctrl_r    <= ctrl_nxt;
      prio_r    <= prio_nxt;
      hrdata    <= (acc && !hwrite) ? rdata_nxt : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // usb-c / welcome screen exclusion
  // ****************************************************************
  always_comb
  begin
    host_att  = sync2_r[NI];
    aud_pres  = sync2_r[NI+1];
    ws_routed = 1'b0;
    for (int o = 0; o < NO; o++)
    begin
      ws_routed = ws_routed || video_route[o*3 +: 3] == pias_pkg::WS_IDX;
    end
    act_seen = sync2_r[NI-1:0];
    // usb-c activity is blind while the generator owns the shared path
    if (ws_routed)
    begin
      act_seen[pias_pkg::USB_C_IDX] = 1'b0;
    end
    // an attached host counts as active even without a picture
    if (host_att)
    begin
      act_seen[pias_pkg::USB_C_IDX] = 1'b1;
      act_seen[pias_pkg::WS_IDX]    = 1'b0;
    end
    rise = act_seen & ~act_prev_r;
  end

  // ****************************************************************
  // per-output selectors
  // ****************************************************************
  logic [NO*3-1:0] video_nxt;
  logic [NO*3-1:0] follow_nxt;
  logic [NO*3-1:0] vpick;
  logic [NO*3-1:0] fpick;
  logic [NO-1:0]   vchg;
  logic [NO-1:0]   fchg;

  for (genvar g = 0; g < NO; g++)
  begin : g_out
    pias_pick #(.NI(NI)) u_vid (
      .active    (act_seen),
      .new_act   (rise),
      .prio      (prio_r[g*NI*PW +: NI*PW]),
      .cur       (video_route[g*3 +: 3]),
      .last_mode (ctrl_r[g*pias_pkg::CTRL_FLD_W +: 2] == 2'(pias_pkg::PIAS_LAST)),
      .change    (vchg[g]),
      .pick      (vpick[g*3 +: 3])
    );
    pias_pick #(.NI(NI)) u_fol (
      .active    (act_seen),
      .new_act   (rise),
      .prio      (prio_r[g*NI*PW +: NI*PW]),
      .cur       (follow_route[g*3 +: 3]),
      .last_mode (ctrl_r[g*pias_pkg::CTRL_FLD_W+2 +: 2] == 2'(pias_pkg::PIAS_LAST)),
      .change    (fchg[g]),
      .pick      (fpick[g*3 +: 3])
    );
  end

  always_comb
  begin
    video_nxt  = video_route;
    follow_nxt = follow_route;
    for (int o = 0; o < NO; o++)
    begin
      // manual wins this cycle; an active policy may override it later
      if (man_vld && 32'(man_out) == o)
      begin
        if (man_layer)
        begin
          follow_nxt[o*3 +: 3] = man_in;
        end
        else
        begin
          video_nxt[o*3 +: 3] = man_in;
        end
      end
      else
      begin
        if (ctrl_r[o*pias_pkg::CTRL_FLD_W +: 2] != 2'(pias_pkg::PIAS_DISABLED) &&
            ctrl_r[o*pias_pkg::CTRL_FLD_W +: 2] != 2'(pias_pkg::PIAS_FOLLOW) && vchg[o])
        begin
          video_nxt[o*3 +: 3] = vpick[o*3 +: 3];
        end
        unique case (ctrl_r[o*pias_pkg::CTRL_FLD_W+2 +: 2])
          2'(pias_pkg::PIAS_FOLLOW):
          begin
            follow_nxt[o*3 +: 3] = video_nxt[o*3 +: 3];
          end
          2'(pias_pkg::PIAS_FIRST), 2'(pias_pkg::PIAS_LAST):
          begin
            if (fchg[o])
            begin
              follow_nxt[o*3 +: 3] = fpick[o*3 +: 3];
            end
          end
          2'(pias_pkg::PIAS_DISABLED):
          begin
          end
        endcase
      end
    end
    // an attached usb-c host claims all: any output on the generator falls back to usb-c
    for (int o = 0; o < NO; o++)
    begin
      if (host_att && video_nxt[o*3 +: 3] == pias_pkg::WS_IDX)
      begin
        video_nxt[o*3 +: 3] = pias_pkg::USB_C_IDX;
      end
    end
    for (int o = 0; o < NO; o++)
    begin
      for (int k = 0; k < NO; k++)
      begin
        // generator refused while usb-c holds any output
        if (video_nxt[o*3 +: 3] == pias_pkg::WS_IDX && video_nxt[k*3 +: 3] == pias_pkg::USB_C_IDX)
        begin
          video_nxt[o*3 +: 3] = video_route[o*3 +: 3] == pias_pkg::WS_IDX ?
                                pias_pkg::NO_INPUT : video_route[o*3 +: 3];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      video_route            <= {NO{pias_pkg::NO_INPUT}};
      follow_route           <= {NO{pias_pkg::NO_INPUT}};
      usb_c_audio_to_analog  <= 1'b0;
      embedded_audio_present <= 1'b0;
    end
    else
    begin
      video_route            <= video_nxt;
      follow_route           <= follow_nxt;
      usb_c_audio_to_analog  <= audio_src_sel == pias_pkg::USB_C_IDX && !ws_routed;
      embedded_audio_present <= aud_pres && !ws_routed;
    end
  end

endmodule : pias_top

// ===== sim/pias_top_props.sv
`timescale 1ns/10ps
// ****
// port checker for the input selector
// ****
module pias_top_props #(
  parameter int unsigned NI = pias_pkg::NUM_IN,
  parameter int unsigned NO = pias_pkg::NUM_OUT
) (
  input logic             hclk,
  input logic             hresetn,
  input logic             hsel,
  input logic [31:0]      haddr,
  input logic [1:0]       htrans,
  input logic             hwrite,
  input logic [2:0]       hsize,
  input logic [31:0]      hwdata,
  input logic             hready,
  input logic [31:0]      hrdata,
  input logic             hreadyout,
  input logic             hresp,
  input logic [NI-1:0]    active_signal_flag,
  input logic             usb_c_host_attached,
  input logic             usb_c_audio_present,
  input logic [2:0]       audio_src_sel,
  input logic [NO*3-1:0]  video_route,
  input logic [NO*3-1:0]  follow_route,
  input logic             usb_c_audio_to_analog,
  input logic             embedded_audio_present
);
  logic ws_on;
  assign ws_on = video_route[2:0] == 3'h4 || video_route[5:3] == 3'h4;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_one_of_two;
    !((video_route[2:0] == 3'h0 || video_route[5:3] == 3'h0) && ws_on);
  endproperty
  a_one_of_two: assert property (p_one_of_two) else $error("usb-c and welcome both routed");
  property p_ws_mutes;
    ws_on && $past(ws_on) |-> !embedded_audio_present && !usb_c_audio_to_analog;
  endproperty
  a_ws_mutes: assert property (p_ws_mutes) else $error("usb-c audio live under welcome");
  property p_audio_sel;
    usb_c_audio_to_analog |-> $past(audio_src_sel) == 3'h0;
  endproperty
  a_audio_sel: assert property (p_audio_sel) else $error("analog audio from wrong input");
  property p_ws_blocks_usb;
    video_route[2:0] == 3'h4 && !usb_c_host_attached |=> video_route[2:0] != 3'h0;
  endproperty
  a_ws_blocks_usb: assert property (p_ws_blocks_usb) else $error("usb-c sensed under welcome");
  property p_host_wins;
    usb_c_host_attached [*8] |-> video_route[2:0] != 3'h4 && video_route[5:3] != 3'h4;
  endproperty
  a_host_wins: assert property (p_host_wins) else $error("welcome kept with host attached");
  // eight idle cycles cover the two sync flops and the route register with margin
  property p_quiet;
    (htrans == 2'b00 && $stable(active_signal_flag) && $stable(usb_c_host_attached)) [*8]
      |=> $stable(video_route) && $stable(follow_route);
  endproperty
  a_quiet: assert property (p_quiet) else $error("route moved without cause");
  property p_route_legal;
    (video_route[2:0] <= 3'h4 || video_route[2:0] == 3'h7) &&
      (video_route[5:3] <= 3'h4 || video_route[5:3] == 3'h7);
  endproperty
  a_route_legal: assert property (p_route_legal) else $error("route names no input");
  property p_rd_zero;
    !($past(hsel) && $past(hready) && $past(htrans) == 2'b10 && !$past(hwrite)) |-> hrdata == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read phase");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");

  c_ws: cover property (ws_on);
  c_host: cover property (usb_c_host_attached && video_route[2:0] == 3'h0);
  c_emb: cover property (embedded_audio_present);
endmodule : pias_top_props

bind pias_top pias_top_props #(.NI(NI), .NO(NO)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .active_signal_flag(active_signal_flag), .usb_c_host_attached(usb_c_host_attached),
  .usb_c_audio_present(usb_c_audio_present), .audio_src_sel(audio_src_sel), .video_route(video_route),
  .follow_route(follow_route), .usb_c_audio_to_analog(usb_c_audio_to_analog),
  .embedded_audio_present(embedded_audio_present)
);

// ===== sim/pias_src.sv
`timescale 1ns/10ps
// ****
// sources on the far side of the crosspoint
// ****
module pias_src (
  input  wire logic       hclk,
  input  wire logic [3:0] want,
  input  wire logic       host_req,
  input  wire logic       aud_req,
  output logic      [4:0] active_signal_flag,
  output logic            usb_c_host_attached,
  output logic            usb_c_audio_present
);
  initial
  begin
    active_signal_flag  = 5'h10;
    usb_c_host_attached = 1'b0;
    usb_c_audio_present = 1'b0;
  end
  // welcome generator is internal and never goes quiet; host may attach with no picture
  always @(posedge hclk)
  begin
    active_signal_flag  <= {1'b1, want};
    usb_c_host_attached <= host_req;
    usb_c_audio_present <= aud_req;
  end
endmodule : pias_src

// ===== sim/priority_input_autoselect_bench.sv
`timescale 1ns/10ps
module priority_input_autoselect_bench;
  // ****
  // bench, partner and reference model
  // ****
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, audio_src_sel;
  logic [4:0]  flag, pa;
  logic [5:0]  video_route, follow_route;
  logic [3:0]  want;
  logic        host_att, aud_pres, host_req, aud_req, usb_aud, emb_aud;
  int          err_count, checked, seed, i;
  int          cur[2], fol[2], pol[2], fpol[2], p[2][5];

  pias_top u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .active_signal_flag(flag), .usb_c_host_attached(host_att),
    .usb_c_audio_present(aud_pres), .audio_src_sel(audio_src_sel), .video_route(video_route),
    .follow_route(follow_route), .usb_c_audio_to_analog(usb_aud), .embedded_audio_present(emb_aud)
  );
  pias_src u_src (.hclk(hclk), .want(want), .host_req(host_req), .aud_req(aud_req),
    .active_signal_flag(flag), .usb_c_host_attached(host_att), .usb_c_audio_present(aud_pres));

  task automatic chk_rd(input logic [31:0] g, e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH read t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [31:0] g, e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH pin t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_pin
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask : done
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  function automatic int best(int o, logic [4:0] m);
    int b = 7;
    for (int k = 0; k < 5; k++)
      if (m[k] && p[o][k] != 0 && (b == 7 || p[o][k] < p[o][b]))
        b = k;
    return b;
  endfunction : best
  // one evaluation per settled step; only single arrivals are stimulated
  task automatic mdl_step;
    logic [4:0] a;
    logic [4:0] n;
    int         c;
    a = {1'b1, want};
    if (host_req)
      a = {1'b0, want[3:1], 1'b1};
    else if (cur[0] == 4 || cur[1] == 4)
      a[0] = 1'b0;
    n = a & ~pa;
    for (int o = 0; o < 2; o++)
    begin
      c = cur[o];
      if (pol[o] == 1 || pol[o] == 3)
      begin
        if (c == 7 || !a[c] || p[o][c] == 0)
          c = best(o, a);
        for (int k = 0; k < 5; k++)
          if (n[k] && p[o][k] != 0 && (c == 7 || p[o][k] < p[o][c] || (pol[o] == 3 && p[o][k] == p[o][c])))
            c = k;
      end
      cur[o] = c;
      if (fpol[o] == 2)
        fol[o] = c;
    end
    pa = a;
  endtask : mdl_step
  task automatic settle;
    repeat (6) @(posedge hclk);
    mdl_step;
    for (int o = 0; o < 2; o++)
    begin
      chk_pin(32'(video_route[3*o+:3]), 32'(cur[o]));
      chk_pin(32'(follow_route[3*o+:3]), 32'(fol[o]));
    end
  endtask : settle
  task automatic wctrl(input logic [7:0] v);
    bus(1'b1, 32'h0000_0000, {24'h00_0000, v});
    for (int o = 0; o < 2; o++)
    begin
      pol[o]  = v[4*o+:2];
      fpol[o] = v[4*o+2+:2];
    end
  endtask : wctrl
  task automatic wprio(input int o, k, input logic [6:0] v);
    bus(1'b1, 32'h0000_0040 + 32'(32 * o + 4 * k), {25'h0, v});
    p[o][k] = (v > 7'h64) ? 100 : int'(v);
  endtask : wprio

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // run is a few hundred cycles; the limit leaves ample room
  initial
  begin
    repeat (5000) @(posedge hclk);
    err_count++;
    end_sim;
  end

  initial
  begin
    {hresetn, hsel, hwrite, host_req, aud_req} = 5'h00;
    {haddr, hwdata, htrans, want, pa} = '0;
    hsize = 3'h2;
    audio_src_sel = 3'h1;
    {err_count, checked} = 0;
    seed = 28608;
    for (int o = 0; o < 2; o++)
    begin
      {cur[o], fol[o], pol[o], fpol[o]} = {32'd7, 32'd7, 64'd0};
      for (int k = 0; k < 5; k++)
        p[o][k] = (k == 4) ? 100 : 50;
    end
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0000_0000, 32'h0); chk_rd(r, 32'h0000_0000);
    bus(1'b0, 32'h0000_0040, 32'h0); chk_rd(r, 32'h0000_0032);
    bus(1'b0, 32'h0000_0070, 32'h0); chk_rd(r, 32'h0000_0064);
    bus(1'b0, 32'h0000_00fc, 32'h0); chk_rd(r, 32'h0000_0000);
    bus(1'b0, 32'h0000_0004, 32'h0); chk_rd(r, 32'h0000_0000);
    bus(1'b0, 32'h0000_0100, 32'h0); chk_rd(r, 32'h003f_003f);
    wprio(1, 0, 7'(101 + $unsigned($random(seed)) % 27));
    bus(1'b0, 32'h0000_0060, 32'h0); chk_rd(r, 32'h0000_0064);
    done("registers");
    want <= 4'h2;
    settle;
    bus(1'b1, 32'h0000_0004, 32'h0000_0002);
    cur[0] = 2;
    settle;
    wctrl(8'h09);
    settle;
    done("manual");
    want <= 4'h6;
    settle;
    wprio(0, 3, 7'h01);
    want <= 4'he;
    settle;
    want <= 4'h6;
    settle;
    bus(1'b1, 32'h0000_0004, 32'h0000_0101);
    cur[1] = 1;
    wctrl(8'h39);
    settle;
    want <= 4'he;
    settle;
    done("detect");
    wctrl(8'h09);
    wprio(0, 2, 7'h00);
    wprio(0, 1, 7'(1 + $unsigned($random(seed)) % 49));
    wprio(0, 3, 7'(51 + $unsigned($random(seed)) % 49));
    settle;
    repeat (12)
    begin
      i = 1 + $unsigned($random(seed)) % 3;
      want <= want ^ 4'(1 << i);
      settle;
    end
    done("random");
    bus(1'b1, 32'h0000_0004, 32'h0001_0102);
    fol[1] = 2;
    want <= 4'h0;
    aud_req <= 1'b1;
    audio_src_sel <= 3'h0;
    settle;
    chk_pin(32'(usb_aud), 32'h0);
    chk_pin(32'(emb_aud), 32'h0);
    want <= 4'h1;
    settle;
    want <= 4'h0;
    host_req <= 1'b1;
    settle;
    chk_pin(32'(usb_aud), 32'h1);
    chk_pin(32'(emb_aud), 32'h1);
    bus(1'b0, 32'h0000_0008, 32'h0); chk_rd(r, 32'h0000_0681);
    done("welcome");
    end_sim;
  end
endmodule : priority_input_autoselect_bench
